// ==== include/tx_avail_pkg.sv ====
// package: constants, carriers and state layouts of the transmit space status block
// assumes: compiled before the design files; no tool-specific settings needed
package tx_avail_pkg;

    // --------------------------------------------------------------
    // sizes and counts
    // --------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int CNT_W = 8;
    localparam logic [8:0] PKT_FIFO_BYTES = 9'h100;
    localparam logic [2:0] CELL_FIFO_CELLS = 3'h4;
    localparam logic [2:0] CELL_DEPTH_BASE = 3'h1;
    localparam logic [4:0] CELL_HDR_WORDS = 5'h03;
    localparam logic [4:0] CELL_LAST_WORD = 5'h1A;
    localparam logic [4:0] PAYLOAD_WORD_EARLY = 5'h13;
    localparam logic [4:0] PAYLOAD_WORD_LATE = 5'h17;
    localparam logic [2:0] NULL_ADDR = 3'h7;
    localparam int LINK_CLK_MAX_MHZ = 50;
    localparam int SYS_CLK_MHZ = 50;

    // --------------------------------------------------------------
    // carriers
    // --------------------------------------------------------------
    typedef logic [NUM_PORTS-1:0][CNT_W-1:0] cnt_vec_t;

    typedef struct packed {
        logic packet_mode;
        logic packet_level_select;
        logic pkt_near_full_enable;
        logic [7:0] pkt_avail_high_watermark;
        logic [7:0] pkt_avail_low_watermark;
        logic [2:0] device_port_address;
        logic cell_full_word_select;
        logic cell_lookahead_enable;
        logic [1:0] cell_full_depth;
    } cfg_s;

    typedef struct packed {
        cfg_s cfg_hold;
        logic req;
        cnt_vec_t rd_bin;
        cnt_vec_t rd_gray;
    } sys_state_s;

    typedef struct packed {
        cfg_s cfg;
        logic ack;
        logic sel;
        logic [1:0] port;
        logic in_cell;
        logic [4:0] word_idx;
        logic early;
        logic commit;
        cnt_vec_t wr_cnt;
        logic [NUM_PORTS-1:0] pkt_flag;
        logic pkt_out;
        logic pkt_out_oe;
        logic [NUM_PORTS-1:0] cell_flags;
    } link_state_s;

    // --------------------------------------------------------------
    // values after reset: every fifo empty, so availability is high
    // --------------------------------------------------------------
    localparam cfg_s CFG_RESET = '0;
    localparam sys_state_s SYS_RESET = '0;
    localparam link_state_s LINK_RESET = '{cfg: CFG_RESET, ack: 1'b0, sel: 1'b0,
        port: 2'h0, in_cell: 1'b0, word_idx: 5'h00, early: 1'b0, commit: 1'b0,
        wr_cnt: '0, pkt_flag: '1, pkt_out: 1'b0, pkt_out_oe: 1'b0, cell_flags: '1};

endpackage : tx_avail_pkg

// ==== hw/bit_sync.sv ====
// bit_sync: two flip-flop synchroniser for levels and gray-coded words
// assumes: each bit of d changes at most once per several destination clocks
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic [W-1:0] d, // level from the other domain
    output logic [W-1:0] q // synchronised level
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clk) begin
        meta_q <= d;
        sync_q <= meta_q;
    end

    assign q = sync_q;
endmodule : bit_sync

// ==== hw/tx_fifo_space_status.sv ====
// tx_fifo_space_status: transmit fifo space flags toward the link-layer writer
// assumes: cfg, rd_port and rd_pulse come from clk_sys logic; tx_* pins are
// synchronous to tfclk; one rd_pulse frees one word (packet) or one cell.
// Operation
// [RULE1] packet flag rises at high-watermark free bytes
// [RULE2] packet flag falls on full or near-full
// [RULE3] packet flag follows the port being written
// [RULE4] packet flag floats while enable is high
// [RULE5] floats for null or foreign selected address
// [RULE6] packet flag driven only in packet-level mode
// [RULE7] packet flag changes only on tfclk rising
// [RULE8] cell mode writes four-cell fifos on tfclk
// [RULE9] packet mode writes 256-byte fifos on tfclk
// [RULE10] writer keeps tfclk at 50 MHz or below
// [RULE11] cell flag high while a cell fits
// [RULE12] cell flag marks near-full or full by choice
// [RULE13] early drop after payload word 19 or 23
// [RULE14] cell full depth programmable one to four
// [RULE15] cell fifo always stores four cells
// [RULE16] after reset all fifos count as empty
`timescale 1ns/1ps
module tx_fifo_space_status (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic tfclk, // transmit fifo write clock from the writer
    input wire tx_avail_pkg::cfg_s cfg, // configuration levels, clk_sys domain
    input wire logic [1:0] rd_port, // port drained by the line side
    input wire logic rd_pulse, // one word or cell drained, clk_sys domain
    input wire logic tx_enable_n, // transmit enable, active low, tfclk domain
    input wire logic [2:0] tx_addr, // transmit address, tfclk domain
    input wire logic tx_soc, // first word of a cell, tfclk domain
    output logic selected_pkt_avail, // packet space flag of the written port
    output logic selected_pkt_avail_oe, // high while the flag pin is driven
    output logic [tx_avail_pkg::NUM_PORTS-1:0] direct_cell_avail // per-port cell space
);
    import tx_avail_pkg::*;

    // --------------------------------------------------------------
    // crossings
    // --------------------------------------------------------------
    sys_state_s sys_q;
    sys_state_s sys_d;
    link_state_s lnk_q;
    link_state_s lnk_d;
    logic lrst;
    logic req_sync;
    logic ack_sync;
    cnt_vec_t rd_gray_sync;

    bit_sync #(.W(1)) u_rst_sync (
        .clk(tfclk),
        .d(srst),
        .q(lrst)
    );

    bit_sync #(.W(1)) u_req_sync (
        .clk(tfclk),
        .d(sys_q.req),
        .q(req_sync)
    );

    bit_sync #(.W(1)) u_ack_sync (
        .clk(clk_sys),
        .d(lnk_q.ack),
        .q(ack_sync)
    );

    bit_sync #(.W(NUM_PORTS * CNT_W)) u_gray_sync (
        .clk(tfclk),
        .d(sys_q.rd_gray),
        .q(rd_gray_sync)
    );

    function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = g;
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // --------------------------------------------------------------
    // system side: config handshake and drain counters
    // --------------------------------------------------------------
    always_comb begin
        sys_d = sys_q;
        // a new word is offered only once the previous one was taken
        if (sys_q.req == ack_sync && cfg != sys_q.cfg_hold) begin
            sys_d.cfg_hold = cfg;
            sys_d.req = !sys_q.req;
        end
        if (rd_pulse) begin
            sys_d.rd_bin[rd_port] = CNT_W'(sys_q.rd_bin[rd_port] + 1'b1);
            sys_d.rd_gray[rd_port] = sys_d.rd_bin[rd_port] ^ (sys_d.rd_bin[rd_port] >> 1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sys_q <= SYS_RESET;
        end else begin
            sys_q <= sys_d;
        end
    end

    // --------------------------------------------------------------
    // link side: decode of the current word
    // --------------------------------------------------------------
    logic cell_mode;
    logic addr_match;
    logic wr_now;
    logic cell_word;
    logic [4:0] word_now;
    logic [4:0] early_idx;
    logic polled_in_use;
    logic early_set;
    logic [2:0] cell_depth;
    logic [CNT_W-1:0] occ [NUM_PORTS];
    logic [8:0] free_bytes [NUM_PORTS];
    logic [NUM_PORTS-1:0] flag_nxt;
    logic [NUM_PORTS-1:0] cell_nxt;

    assign cell_mode = !lnk_q.cfg.packet_mode;
    assign addr_match = (tx_addr != NULL_ADDR) &&
        (tx_addr[2] == lnk_q.cfg.device_port_address[2]);
    assign wr_now = !tx_enable_n && lnk_q.sel;
    assign cell_word = cell_mode && wr_now && (tx_soc || lnk_q.in_cell);
    assign word_now = tx_soc ? 5'h00 : lnk_q.word_idx;
    assign early_idx = 5'(CELL_HDR_WORDS - 5'h01 +
        (lnk_q.cfg.cell_full_word_select ? PAYLOAD_WORD_LATE : PAYLOAD_WORD_EARLY));
    assign polled_in_use = addr_match && (tx_addr[1:0] == lnk_q.port);
    assign early_set = cell_word && lnk_q.cfg.cell_lookahead_enable && // RULE12
        polled_in_use && (word_now == early_idx); // RULE13
    assign cell_depth = {1'b0, lnk_q.cfg.cell_full_depth} + CELL_DEPTH_BASE; // RULE14

    // --------------------------------------------------------------
    // per-port occupancy and flags
    // --------------------------------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic hit;
        logic [CNT_W-1:0] eff;

        assign occ[p] = CNT_W'(lnk_q.wr_cnt[p] - gray2bin(rd_gray_sync[p]));
        assign free_bytes[p] = 9'(PKT_FIFO_BYTES - {occ[p], 1'b0});

        // hysteresis between the two watermarks
        always_comb begin
            if (lnk_q.pkt_flag[p]) begin
                flag_nxt[p] = !((free_bytes[p] == 9'h000) || // RULE2
                    (lnk_q.cfg.pkt_near_full_enable &&
                    (free_bytes[p] < {1'b0, lnk_q.cfg.pkt_avail_low_watermark})));
            end else begin
                // a full fifo never raises the flag, even with a zero high watermark
                flag_nxt[p] = (free_bytes[p] != 9'h000) && // RULE2
                    (free_bytes[p] >= {1'b0, lnk_q.cfg.pkt_avail_high_watermark}); // RULE1
            end
        end

        // the cell being written counts from the edge after its look-ahead word
        assign hit = lnk_q.early && (lnk_q.port == 2'(p)); // RULE13
        assign eff = CNT_W'(occ[p] + {7'h00, hit});
        assign cell_nxt[p] = (eff < {5'h00, cell_depth}) && // RULE11
            (eff < {5'h00, CELL_FIFO_CELLS}); // RULE15
    end

    // --------------------------------------------------------------
    // link side state
    // --------------------------------------------------------------
    always_comb begin
        lnk_d = lnk_q;
        lnk_d.commit = 1'b0;
        if (lnk_q.ack != req_sync) begin
            lnk_d.cfg = sys_q.cfg_hold;
            lnk_d.ack = req_sync;
        end
        // selection is taken from the address seen while enable is high
        if (tx_enable_n) begin
            lnk_d.sel = addr_match; // RULE5
            lnk_d.port = tx_addr[1:0];
        end
        if (lnk_q.commit) begin
            lnk_d.early = 1'b0;
        end
        if (cell_word) begin // RULE8
            lnk_d.word_idx = 5'(word_now + 5'h01);
            lnk_d.in_cell = (word_now != CELL_LAST_WORD);
            if (early_set) begin
                lnk_d.early = 1'b1;
            end
            if (word_now == CELL_LAST_WORD) begin
                lnk_d.wr_cnt[lnk_q.port] = CNT_W'(lnk_q.wr_cnt[lnk_q.port] + 1'b1);
                lnk_d.commit = 1'b1;
            end
        end else if (!cell_mode && wr_now) begin
            lnk_d.wr_cnt[lnk_q.port] = CNT_W'(lnk_q.wr_cnt[lnk_q.port] + 1'b1); // RULE9
        end
        lnk_d.pkt_flag = flag_nxt;
        lnk_d.cell_flags = cell_nxt;
        lnk_d.pkt_out = flag_nxt[lnk_d.port]; // RULE3
        lnk_d.pkt_out_oe = lnk_q.cfg.packet_mode && lnk_q.cfg.packet_level_select && // RULE6
            !tx_enable_n && lnk_q.sel; // RULE4
    end

    // all link flags move on tfclk only
    always_ff @(posedge tfclk) begin // RULE7
        if (lrst) begin
            lnk_q <= LINK_RESET; // RULE16
        end else begin
            lnk_q <= lnk_d;
        end
    end

    assign selected_pkt_avail = lnk_q.pkt_out;
    assign selected_pkt_avail_oe = lnk_q.pkt_out_oe;
    assign direct_cell_avail = lnk_q.cell_flags;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence s_null_select;
        tx_enable_n && (tx_addr == NULL_ADDR) ##1 !tx_enable_n;
    endsequence

    sequence s_early_word;
        early_set && (CNT_W'(occ[lnk_q.port] + 8'h01) >= {5'h00, cell_depth});
    endsequence

    chk_float_on_enable: assert property ( // RULE4
        @(posedge tfclk) disable iff (lrst)
        tx_enable_n |=> !selected_pkt_avail_oe)
        else $error("packet flag driven while enable deasserted");

    chk_float_null_addr: assert property ( // RULE5
        @(posedge tfclk) disable iff (lrst)
        s_null_select |=> !selected_pkt_avail_oe)
        else $error("packet flag driven after null address");

    chk_float_byte_mode: assert property ( // RULE6
        @(posedge tfclk) disable iff (lrst)
        !(lnk_q.cfg.packet_mode && lnk_q.cfg.packet_level_select)
        |=> !selected_pkt_avail_oe)
        else $error("packet flag driven outside packet-level mode");

    chk_drive_selected: assert property ( // RULE6
        @(posedge tfclk) disable iff (lrst)
        lnk_q.cfg.packet_mode && lnk_q.cfg.packet_level_select && lnk_q.sel &&
        !tx_enable_n |=> selected_pkt_avail_oe)
        else $error("packet flag not driven for a selected port");

    chk_flag_rises_hwm: assert property ( // RULE1
        @(posedge tfclk) disable iff (lrst)
        !tx_enable_n && !lnk_q.pkt_flag[lnk_q.port] && (free_bytes[lnk_q.port] != 9'h000) &&
        (free_bytes[lnk_q.port] >= {1'b0, lnk_q.cfg.pkt_avail_high_watermark})
        |=> selected_pkt_avail)
        else $error("packet flag missed the high watermark");

    chk_flag_falls_full: assert property ( // RULE2
        @(posedge tfclk) disable iff (lrst)
        !tx_enable_n && (free_bytes[lnk_q.port] == 9'h000) |=> !selected_pkt_avail)
        else $error("packet flag high with a full fifo");

    chk_cell_full_depth: assert property ( // RULE14
        @(posedge tfclk) disable iff (lrst)
        cell_mode && (occ[0] >= {5'h00, cell_depth}) |=> !direct_cell_avail[0])
        else $error("cell flag high at the full depth");

    chk_cell_early_drop: assert property ( // RULE13
        @(posedge tfclk) disable iff (lrst)
        s_early_word |=> ##1 !direct_cell_avail[$past(lnk_q.port, 2)])
        else $error("cell flag not dropped after look-ahead word");

    chk_flag_follows_port: assert property ( // RULE3
        @(posedge tfclk) disable iff (lrst)
        !tx_enable_n |=> selected_pkt_avail == lnk_q.pkt_flag[lnk_q.port])
        else $error("packet flag not taken from the written port");

    chk_cell_room_high: assert property ( // RULE11
        @(posedge tfclk) disable iff (lrst)
        cell_mode && !lnk_q.early && (occ[0] < {5'h00, cell_depth})
        |=> direct_cell_avail[0])
        else $error("cell flag low while a cell fits");

    chk_pkt_word_count: assert property ( // RULE9
        @(posedge tfclk) disable iff (lrst)
        !cell_mode && wr_now && (lnk_q.port == 2'h0)
        |=> lnk_q.wr_cnt[0] == CNT_W'($past(lnk_q.wr_cnt[0]) + 1'b1))
        else $error("packet word not counted");

    chk_reset_empty: assert property ( // RULE16
        @(posedge tfclk)
        lrst |=> (lnk_q.wr_cnt == '0) && (direct_cell_avail == '1))
        else $error("fifos not empty after reset");

endmodule : tx_fifo_space_status

// ==== verification/link_writer.sv ====
// link_writer: behavioural link-layer writer driving the transmit fifo pins
// assumes: the bench calls one task at a time; pins change 2 ns after tfclk rises
`timescale 1ns/1ps
module link_writer (
    output logic tfclk, // transmit fifo write clock, free running
    output logic tx_enable_n, // transmit enable, active low
    output logic [2:0] tx_addr, // transmit address
    output logic tx_soc // first word of a cell
);
    // ----------------------------------------------------------------
    // clock and idle levels
    // ----------------------------------------------------------------
    initial begin
        tfclk = 1'b0;
        tx_enable_n = 1'b1;
        tx_addr = 3'h7;
        tx_soc = 1'b0;
        #7;
        forever #16 tfclk = ~tfclk;
    end

    // ----------------------------------------------------------------
    // transfers
    // ----------------------------------------------------------------
    // one select cycle, then n enabled cycles, each writing one word
    task automatic write_words(input logic [2:0] a, input int n);
        @(posedge tfclk);
        #2;
        tx_addr = a;
        @(posedge tfclk);
        #2;
        tx_enable_n = 1'b0;
        repeat (n) @(posedge tfclk);
        #2;
        tx_enable_n = 1'b1;
        tx_addr = 3'h7;
    endtask : write_words

    // one select cycle, then a whole 27-word cell with the address held
    task automatic write_cell(input logic [2:0] a);
        @(posedge tfclk);
        #2;
        tx_addr = a;
        @(posedge tfclk);
        #2;
        tx_enable_n = 1'b0;
        tx_soc = 1'b1;
        @(posedge tfclk);
        #2;
        tx_soc = 1'b0;
        repeat (26) @(posedge tfclk);
        #2;
        tx_enable_n = 1'b1;
        tx_addr = 3'h7;
    endtask : write_cell
endmodule : link_writer

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench of the transmit space status block
// assumes: link_writer stands in for the link layer; cfg and drains from clk_sys
`timescale 1ns/1ps
module tb_top;
    import tx_avail_pkg::*;
    logic clk_sys, srst, rd_pulse, tfclk, tx_enable_n, tx_soc;
    logic selected_pkt_avail, selected_pkt_avail_oe, seen_oe, seen_flag, seen_off, dca_prev;
    logic [2:0] tx_addr;
    logic [1:0] rd_port;
    logic [NUM_PORTS-1:0] direct_cell_avail;
    cfg_s cfg;
    int bad_count, n_compared, fall_k, k;

    link_writer w (.tfclk(tfclk), .tx_enable_n(tx_enable_n), .tx_addr(tx_addr),
        .tx_soc(tx_soc));
    tx_fifo_space_status uut (.clk_sys(clk_sys), .srst(srst), .tfclk(tfclk), .cfg(cfg),
        .rd_port(rd_port), .rd_pulse(rd_pulse), .tx_enable_n(tx_enable_n),
        .tx_addr(tx_addr), .tx_soc(tx_soc), .selected_pkt_avail(selected_pkt_avail),
        .selected_pkt_avail_oe(selected_pkt_avail_oe), .direct_cell_avail(direct_cell_avail));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // word index of the cell in flight and where port 3 cell flag fell
    // ----------------------------------------------------------------
    initial begin
        k = 0;
        fall_k = 0;
        dca_prev = 1'b1;
        forever begin
            @(posedge tfclk);
            k = (tx_soc === 1'b1) ? 0 : k + 1;
            #1;
            if (dca_prev === 1'b1 && direct_cell_avail[3] === 1'b0) fall_k = k;
            dca_prev = direct_cell_avail[3];
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic settle;
        repeat (6) @(posedge tfclk);
        #1;
    endtask : settle

    task automatic apply_cfg(input cfg_s nc);
        @(posedge clk_sys);
        #2;
        cfg = nc;
        repeat (12) @(posedge tfclk);
        #1;
    endtask : apply_cfg

    // one unit per pulse, pulses far enough apart for the link clock
    task automatic drain(input logic [1:0] p, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #2;
            rd_port = p;
            rd_pulse = 1'b1;
            @(posedge clk_sys);
            #2;
            rd_pulse = 1'b0;
            repeat (3) @(posedge clk_sys);
        end
        settle();
    endtask : drain

    // two words to address a; pin state while enabled and after release
    task automatic probe(input logic [2:0] a);
        w.write_words(a, 2);
        seen_oe = selected_pkt_avail_oe;
        seen_flag = selected_pkt_avail;
        repeat (2) @(posedge tfclk);
        #1;
        seen_off = selected_pkt_avail_oe;
    endtask : probe

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_pkt;
        cfg_s c;
        c = '0;
        c.packet_mode = 1'b1;
        c.packet_level_select = 1'b1;
        c.pkt_avail_high_watermark = 8'h10;
        c.pkt_avail_low_watermark = 8'h08;
        apply_cfg(c);
        w.write_words(3'h1, 128);
        probe(3'h2);
        check(8'(seen_oe), 8'h01);
        check(8'(seen_flag), 8'h01);
        check(8'(seen_off), 8'h00);
        drain(2'h1, 7);
        probe(3'h1);
        check(8'(seen_flag), 8'h00);
        drain(2'h1, 4);
        probe(3'h1);
        check(8'(seen_flag), 8'h01);
        c.pkt_near_full_enable = 1'b1;
        c.pkt_avail_low_watermark = 8'h20;
        c.pkt_avail_high_watermark = 8'h40;
        apply_cfg(c);
        probe(3'h1);
        check(8'(seen_flag), 8'h00);
        probe(3'h5);
        check(8'(seen_oe), 8'h00);
        probe(3'h7);
        check(8'(seen_oe), 8'h00);
        c.packet_level_select = 1'b0;
        apply_cfg(c);
        probe(3'h2);
        check(8'(seen_oe), 8'h00);
    endtask : t_pkt

    // only ports 0 and 3 are judged: ports 1 and 2 keep packet word counts
    task automatic t_cell_depth;
        cfg_s c;
        c = '0;
        c.cell_full_depth = 2'h1;
        apply_cfg(c);
        w.write_cell(3'h0);
        settle();
        check(8'({direct_cell_avail[3], direct_cell_avail[0]}), 8'h03);
        w.write_cell(3'h0);
        settle();
        check(8'({direct_cell_avail[3], direct_cell_avail[0]}), 8'h02);
        c.cell_full_depth = 2'h3;
        apply_cfg(c);
        check(8'({direct_cell_avail[3], direct_cell_avail[0]}), 8'h03);
        w.write_cell(3'h0);
        w.write_cell(3'h0);
        settle();
        check(8'({direct_cell_avail[3], direct_cell_avail[0]}), 8'h02);
        drain(2'h0, 4);
        check(8'({direct_cell_avail[3], direct_cell_avail[0]}), 8'h03);
    endtask : t_cell_depth

    task automatic t_cell_early;
        cfg_s c;
        c = '0;
        c.cell_lookahead_enable = 1'b1;
        for (int s = 0; s < 2; s++) begin
            c.cell_full_word_select = s[0];
            apply_cfg(c);
            fall_k = 0;
            w.write_cell(3'h3);
            check(8'(fall_k), (s == 1) ? 8'h1A : 8'h16);
            drain(2'h3, 1);
            check(8'(direct_cell_avail[3]), 8'h01);
        end
    endtask : t_cell_early

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        bad_count = 0;
        n_compared = 0;
        cfg = '0;
        srst = 1'b1;
        rd_pulse = 1'b0;
        rd_port = 2'h0;
        repeat (8) @(posedge clk_sys);
        #2;
        srst = 1'b0;
        repeat (10) @(posedge tfclk);
        #1;
        check(8'(direct_cell_avail), 8'h0F);
        check(8'(selected_pkt_avail_oe), 8'h00);
        t_pkt();
        t_cell_depth();
        t_cell_early();
        tally_and_finish();
    end

    initial begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
endmodule : tb_top
